// *** rtl/umscp_cmd_parser.sv ***
// UART mode switch and ASCII command front end
// Function
// R01: Start in data mode after reset
// R02: Network payload goes out the UART
// R03: UART bytes go to network side
// R04: Only isolated triple dollar enters command mode
// R05: Padded or split escape is rejected
// R06: Escape switches mode and sends CMD
// R07: Exit keyword plus CR returns to data
// R08: UART defaults to 9600 8N1
// R09: Prompt with version after each command; none after exit, which sends EXIT and returns to data mode
// R10: Keyword plus parameters, case sensitive
// R11: No spaces; dollar means space
// R12: Prefixes of group words are accepted
// R13: Keywords must match in full
// R14: Set and get know eleven groups; get also everything
// R15: Bad line gives error, prompt, stays
`timescale 1ns/1ps
`default_nettype none
module umscp_cmd_parser #(
  parameter int unsigned BIT_CYC   = umscp_pkg::BIT_CYC,
  parameter int unsigned GUARD_CYC = umscp_pkg::GUARD_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       uart_rxd,
  output logic            uart_txd,
  input  wire logic [7:0] net_rx_data,
  input  wire logic       net_rx_valid,
  output logic            net_rx_ready,
  output logic [7:0]      net_tx_data,
  output logic            net_tx_valid,
  output logic            cmd_mode,
  output logic            cmd_valid,
  output logic            cmd_is_set,
  output logic [3:0]      cmd_grp,
  output logic [7:0]      param_data,
  output logic            param_valid
);
  import umscp_pkg::*;

  localparam logic [23:0] GUARD = 24'(GUARD_CYC);  // Escape silence in cycles

  // UART side
  logic [7:0] rx_data;                    // Received byte
  logic       rx_valid;                   // Received byte pulse
  logic       tx_busy;                    // Transmitter occupied
  logic [7:0] tx_byte, next_tx_byte;      // Byte to send
  logic       tx_start, next_tx_start;    // Send pulse

  // Mode and reply sender
  umscp_state_e state, next_state;
  umscp_msg_e   msg, next_msg;            // Reply being sent
  logic [3:0]   msg_idx, next_msg_idx;    // Character within reply
  logic         then_prompt, next_then_prompt;
  logic         go_data, next_go_data;    // Leave command mode after reply

  // Escape detector
  logic [23:0] idle_cnt, next_idle_cnt;   // Cycles since last received byte
  logic [1:0]  esc_cnt, next_esc_cnt;     // Dollars seen so far
  logic        guard_met;

  // Line parser
  logic [1:0]          tok, next_tok;     // Token number, 3 saturates
  logic [3:0]          pos, next_pos;     // Position in token, saturating
  logic [KW_NUM-1:0]   kw_mask, next_kw_mask;
  logic [GRP_NUM-1:0]  grp_mask, next_grp_mask;
  umscp_kw_e           kw, next_kw;       // Keyword of this line
  logic [3:0]          grp, next_grp;     // Group of this line
  logic                bad, next_bad;     // Line already known to be bad

  // Token close results
  umscp_kw_e  fin_kw, cl_kw;
  logic [3:0] fin_grp, cl_grp;
  logic       fin_hit, cl_bad;
  logic [1:0] cl_tok;

  // Registered outputs
  logic       next_net_rx_ready, next_net_tx_valid, next_cmd_mode;
  logic       next_cmd_valid, next_cmd_is_set, next_param_valid;
  logic [7:0] next_net_tx_data, next_param_data;
  logic [3:0] next_cmd_grp;

  // Reply text; prompt carries the version digits
  function automatic logic [79:0] msg_str(input umscp_msg_e m);
    case (m)
      MSG_CMD:  return TXT_CMD;
      MSG_ERR:  return TXT_ERR;
      MSG_EXIT: return TXT_EXIT;
      default:  return {24'h00_0000, CH_LT, VER_MAJ, CH_DOT, VER_MI1, VER_MI2, CH_GT, CH_SPACE};
    endcase
  endfunction : msg_str

  // Reply length
  function automatic logic [3:0] msg_len(input umscp_msg_e m);
    case (m)
      MSG_CMD:  return LEN_CMD;
      MSG_ERR:  return LEN_ERR;
      MSG_EXIT: return LEN_EXIT;
      default:  return LEN_PROMPT;
    endcase
  endfunction : msg_len

  umscp_uart #(
    .BIT_CYC (BIT_CYC)
  ) u_uart (
    .clk      (clk),
    .rst_n    (rst_n),
    .rxd      (uart_rxd),
    .txd      (uart_txd),
    .rx_data  (rx_data),
    .rx_valid (rx_valid),
    .tx_data  (tx_byte),
    .tx_start (tx_start),
    .tx_busy  (tx_busy)
  );

  assign guard_met = (idle_cnt >= GUARD);

  // Token close: keyword exact, group by prefix, lowest index wins
  always_comb
  begin
    fin_kw = KW_NONE;
    for (int i = KW_NUM - 1; i >= 0; i--)
      if (kw_mask[i] && pos == KW_LEN[i])
        fin_kw = umscp_kw_e'(i[1:0]);      // R13
    fin_grp = 4'h0;
    fin_hit = 1'b0;
    for (int i = GRP_NUM - 1; i >= 0; i--)
      if (grp_mask[i])
      begin
        fin_grp = i[3:0];                  // R12
        fin_hit = 1'b1;
      end
    cl_kw  = kw;
    cl_grp = grp;
    cl_bad = bad;
    cl_tok = tok;
    if (pos != 4'h0)
    begin
      cl_tok = (tok == 2'h3) ? tok : tok + 2'h1;
      case (tok)
        2'h0:
        begin
          cl_kw = fin_kw;
          if (fin_kw == KW_NONE)
            cl_bad = 1'b1;                 // R13
        end
        2'h1:
        begin
          cl_grp = fin_grp;
          // Exit takes no parameter; only get reports everything
          if (kw == KW_EXIT || !fin_hit || (kw == KW_SET && fin_grp == GRP_ALL))
            cl_bad = 1'b1;                 // R14
        end
        default: ;
      endcase
    end
  end

  // Mode, escape detector, parser and sender next values
  always_comb
  begin
    next_state        = state;
    next_msg          = msg;
    next_msg_idx      = msg_idx;
    next_then_prompt  = then_prompt;
    next_go_data      = go_data;
    next_tx_byte      = tx_byte;
    next_tx_start     = 1'b0;
    next_esc_cnt      = esc_cnt;
    next_tok          = tok;
    next_pos          = pos;
    next_kw_mask      = kw_mask;
    next_grp_mask     = grp_mask;
    next_kw           = kw;
    next_grp          = grp;
    next_bad          = bad;
    next_net_tx_data  = net_tx_data;
    next_net_tx_valid = 1'b0;
    next_cmd_mode     = cmd_mode;
    next_cmd_valid    = 1'b0;
    next_cmd_is_set   = cmd_is_set;
    next_cmd_grp      = cmd_grp;
    next_param_data   = param_data;
    next_param_valid  = 1'b0;
    // Silence timer saturates at the guard time
    if (rx_valid)
      next_idle_cnt = 24'h00_0000;
    else if (!guard_met)
      next_idle_cnt = idle_cnt + 24'h00_0001;
    else
      next_idle_cnt = idle_cnt;
    case (state)
      ST_DATA:
      begin
        if (rx_valid)
        begin
          // Every byte is payload, dollars included
          next_net_tx_data  = rx_data;     // R03
          next_net_tx_valid = 1'b1;        // R03
          if (rx_data != CH_DOLLAR)
            next_esc_cnt = 2'h0;           // R04
          else if (guard_met)
            next_esc_cnt = 2'h1;           // R04
          else if (esc_cnt != 2'h0 && esc_cnt != ESC_COUNT)
            next_esc_cnt = esc_cnt + 2'h1; // R05
          else
            next_esc_cnt = 2'h0;           // R05
        end
        else if (esc_cnt == ESC_COUNT && guard_met)
        begin
          // Quiet after the third dollar completes the escape
          next_esc_cnt     = 2'h0;
          next_state       = ST_SEND;      // R06
          next_msg         = MSG_CMD;      // R06
          next_msg_idx     = 4'h0;
          next_then_prompt = 1'b0;
          next_go_data     = 1'b0;
          next_cmd_mode    = 1'b1;
        end
        if (net_rx_valid && net_rx_ready)
        begin
          next_tx_byte  = net_rx_data;     // R02
          next_tx_start = 1'b1;            // R02
        end
      end
      ST_CMD:
      begin
        if (rx_valid && rx_data == CH_CR)
        begin
          // Line complete: judge it and queue the reply
          next_state    = ST_SEND;
          next_msg_idx  = 4'h0;
          next_tok      = 2'h0;
          next_pos      = 4'h0;
          next_kw_mask  = '1;
          next_grp_mask = '1;
          next_kw       = KW_NONE;
          next_bad      = 1'b0;
          if (cl_tok == 2'h0)
          begin
            next_msg         = MSG_PROMPT;
            next_then_prompt = 1'b0;
          end
          else if (cl_bad || (cl_kw != KW_EXIT && cl_tok == 2'h1))
          begin
            next_msg         = MSG_ERR;    // R15
            next_then_prompt = 1'b1;       // R15
          end
          else if (cl_kw == KW_EXIT)
          begin
            next_msg         = MSG_EXIT;   // R07
            next_then_prompt = 1'b0;
            next_go_data     = 1'b1;       // R07
          end
          else
          begin
            next_msg         = MSG_PROMPT; // R09
            next_then_prompt = 1'b0;
            next_cmd_valid   = 1'b1;       // R10
            next_cmd_is_set  = (cl_kw == KW_SET);
            next_cmd_grp     = cl_grp;     // R14
          end
        end
        else if (rx_valid && rx_data == CH_SPACE)
        begin
          // Space only separates; repeated spaces collapse
          if (pos != 4'h0)
          begin
            next_tok      = cl_tok;        // R11
            next_kw       = cl_kw;
            next_grp      = cl_grp;
            next_bad      = cl_bad;
            next_pos      = 4'h0;
            next_kw_mask  = '1;
            next_grp_mask = '1;
            if (tok >= 2'h2)
            begin
              next_param_data  = CH_NUL;
              next_param_valid = 1'b1;
            end
          end
        end
        else if (rx_valid && rx_data != CH_LF)
        begin
          next_pos = (pos == 4'hF) ? pos : pos + 4'h1;
          // Exact byte compare keeps case significant
          for (int i = 0; i < KW_NUM; i++)
            next_kw_mask[i] = kw_mask[i] &&
              (str_char(KW_NAME[i], KW_LEN[i], pos) == rx_data);   // R10
          for (int i = 0; i < GRP_NUM; i++)
            next_grp_mask[i] = grp_mask[i] &&
              (str_char(GRP_NAME[i], GRP_LEN[i], pos) == rx_data); // R12
          if (tok >= 2'h2)
          begin
            next_param_data  = (rx_data == CH_DOLLAR) ? CH_SPACE : rx_data; // R11
            next_param_valid = 1'b1;
          end
        end
      end
      ST_SEND:
      begin
        // Bytes received while replying are dropped
        if (!tx_busy && !tx_start)
        begin
          if (msg_idx < msg_len(msg))
          begin
            next_tx_byte  = str_char(msg_str(msg), msg_len(msg), msg_idx); // R09
            next_tx_start = 1'b1;
            next_msg_idx  = msg_idx + 4'h1;
          end
          else if (then_prompt)
          begin
            next_msg         = MSG_PROMPT; // R15
            next_msg_idx     = 4'h0;
            next_then_prompt = 1'b0;
          end
          else if (go_data)
          begin
            next_state    = ST_DATA;       // R07
            next_go_data  = 1'b0;
            next_cmd_mode = 1'b0;
          end
          else
            next_state = ST_CMD;
        end
      end
      default: next_state = ST_DATA;
    endcase
    // Accept payload only when the transmitter is surely free
    next_net_rx_ready = (state == ST_DATA) && (next_state == ST_DATA) &&
                        !tx_busy && !tx_start && !next_tx_start;
  end

  // State registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state        <= ST_DATA;             // R01
      msg          <= MSG_PROMPT;
      msg_idx      <= 4'h0;
      then_prompt  <= 1'b0;
      go_data      <= 1'b0;
      tx_byte      <= 8'h00;
      tx_start     <= 1'b0;
      idle_cnt     <= GUARD;               // Line counts as quiet at start
      esc_cnt      <= 2'h0;
      tok          <= 2'h0;
      pos          <= 4'h0;
      kw_mask      <= '1;
      grp_mask     <= '1;
      kw           <= KW_NONE;
      grp          <= 4'h0;
      bad          <= 1'b0;
      net_rx_ready <= 1'b0;
      net_tx_data  <= 8'h00;
      net_tx_valid <= 1'b0;
      cmd_mode     <= 1'b0;                // R01
      cmd_valid    <= 1'b0;
      cmd_is_set   <= 1'b0;
      cmd_grp      <= 4'h0;
      param_data   <= 8'h00;
      param_valid  <= 1'b0;
    end
    else
    begin
      state        <= next_state;
      msg          <= next_msg;
      msg_idx      <= next_msg_idx;
      then_prompt  <= next_then_prompt;
      go_data      <= next_go_data;
      tx_byte      <= next_tx_byte;
      tx_start     <= next_tx_start;
      idle_cnt     <= next_idle_cnt;
      esc_cnt      <= next_esc_cnt;
      tok          <= next_tok;
      pos          <= next_pos;
      kw_mask      <= next_kw_mask;
      grp_mask     <= next_grp_mask;
      kw           <= next_kw;
      grp          <= next_grp;
      bad          <= next_bad;
      net_rx_ready <= next_net_rx_ready;
      net_tx_data  <= next_net_tx_data;
      net_tx_valid <= next_net_tx_valid;
      cmd_mode     <= next_cmd_mode;
      cmd_valid    <= next_cmd_valid;
      cmd_is_set   <= next_cmd_is_set;
      cmd_grp      <= next_cmd_grp;
      param_data   <= next_param_data;
      param_valid  <= next_param_valid;
    end
  end

endmodule : umscp_cmd_parser
`default_nettype wire

// *** rtl/umscp_pkg.sv ***
// Constants, types and string helpers shared by the mode switch and its UART
package umscp_pkg;

  // Clock and serial line defaults
  localparam int unsigned CLK_HZ    = 40_000_000;     // System clock rate
  localparam int unsigned BAUD      = 9600;           // Default line rate
  localparam int unsigned BIT_CYC   = CLK_HZ / BAUD;  // Cycles per bit, 4166
  localparam int unsigned GUARD_MS  = 250;            // Silence around escape, ms
  localparam int unsigned GUARD_CYC = (CLK_HZ / 1000) * GUARD_MS;

  // Characters the parser reacts to
  localparam logic [7:0] CH_DOLLAR = 8'h24;  // Escape and space stand-in
  localparam logic [7:0] CH_SPACE  = 8'h20;  // Token separator
  localparam logic [7:0] CH_CR     = 8'h0D;  // Line end
  localparam logic [7:0] CH_LF     = 8'h0A;  // Ignored in command mode
  localparam logic [7:0] CH_NUL    = 8'h00;  // Parameter separator on param port
  localparam logic [7:0] CH_LT     = 8'h3C;  // Prompt open
  localparam logic [7:0] CH_GT     = 8'h3E;  // Prompt close
  localparam logic [7:0] CH_DOT    = 8'h2E;  // Version dot

  // Firmware version digits, values arbitrary
  localparam logic [7:0] VER_MAJ = 8'h31;
  localparam logic [7:0] VER_MI1 = 8'h30;
  localparam logic [7:0] VER_MI2 = 8'h30;

  localparam logic [1:0] ESC_COUNT = 2'h3;  // Dollars in an escape
  localparam int unsigned KW_NUM   = 3;     // Command keywords known
  localparam int unsigned GRP_NUM  = 12;    // Groups plus the report-all word
  localparam logic [3:0] GRP_ALL   = 4'hB;  // Index of the report-all word

  // Parser and sender modes
  typedef enum logic [1:0] {ST_DATA, ST_CMD, ST_SEND} umscp_state_e;
  typedef enum logic [1:0] {KW_EXIT, KW_SET, KW_GET, KW_NONE} umscp_kw_e;
  typedef enum logic [1:0] {MSG_CMD, MSG_ERR, MSG_EXIT, MSG_PROMPT} umscp_msg_e;

  // Keyword table, right-justified text with lengths
  localparam logic [79:0] KW_NAME [KW_NUM] = '{80'("exit"), 80'("set"), 80'("get")};
  localparam logic [3:0]  KW_LEN  [KW_NUM] = '{4'h4, 4'h3, 4'h3};

  // Parameter groups; last entry reports everything
  localparam logic [79:0] GRP_NAME [GRP_NUM] = '{
    80'("adhoc"), 80'("broadcast"), 80'("comm"), 80'("dns"), 80'("ftp"), 80'("ip"),
    80'("option"), 80'("sys"), 80'("time"), 80'("uart"), 80'("wlan"), 80'("everything")};
  localparam logic [3:0]  GRP_LEN  [GRP_NUM] = '{
    4'h5, 4'h9, 4'h4, 4'h3, 4'h3, 4'h2, 4'h6, 4'h3, 4'h4, 4'h4, 4'h4, 4'hA};

  // Fixed replies
  localparam logic [79:0] TXT_CMD  = 80'("CMD\r\n");
  localparam logic [79:0] TXT_ERR  = 80'("ERR\r\n");
  localparam logic [79:0] TXT_EXIT = 80'("EXIT\r\n");
  localparam logic [3:0]  LEN_CMD  = 4'h5;
  localparam logic [3:0]  LEN_ERR  = 4'h5;
  localparam logic [3:0]  LEN_EXIT = 4'h6;
  localparam logic [3:0]  LEN_PROMPT = 4'h7;

  // Character at a position of a right-justified string; zero past its end
  function automatic logic [7:0] str_char(input logic [79:0] s, input logic [3:0] len,
                                          input logic [3:0] pos);
    logic [7:0] c;
    c = CH_NUL;
    if (pos < len)
      c = s[8 * (int'(len) - 1 - int'(pos)) +: 8];
    return c;
  endfunction : str_char

endpackage : umscp_pkg

// *** rtl/umscp_uart.sv ***
// 8N1 UART transceiver with synchronised receive line
`timescale 1ns/1ps
`default_nettype none
module umscp_uart #(
  parameter int unsigned BIT_CYC = umscp_pkg::BIT_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       rxd,
  output logic            txd,
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_start,
  output logic            tx_busy
);
  import umscp_pkg::*;

  typedef enum logic {RX_IDLE, RX_BUSY} umscp_rx_e;

  logic        rx_s1, rx_s2;              // Two-stage synchroniser
  umscp_rx_e   rx_st, next_rx_st;         // Receiver phase
  logic [15:0] rx_cnt, next_rx_cnt;       // Bit timer
  logic [3:0]  rx_bit, next_rx_bit;       // Bit index, 0 is start
  logic [7:0]  next_rx_data;
  logic        next_rx_valid;
  logic [15:0] tx_cnt, next_tx_cnt;       // Bit timer
  logic [3:0]  tx_bit, next_tx_bit;       // Bit index within frame
  logic [9:0]  tx_sh, next_tx_sh;         // Frame shifter
  logic        next_txd, next_tx_busy;

  // Receive and transmit next state; fixed 8N1 framing
  always_comb
  begin
    next_rx_st    = rx_st;
    next_rx_cnt   = rx_cnt;
    next_rx_bit   = rx_bit;
    next_rx_data  = rx_data;
    next_rx_valid = 1'b0;
    next_tx_cnt   = tx_cnt;
    next_tx_bit   = tx_bit;
    next_tx_sh    = tx_sh;
    next_txd      = txd;
    next_tx_busy  = tx_busy;
    case (rx_st)
      RX_IDLE:
      begin
        // Falling edge starts a frame; sample at mid-bit
        if (!rx_s2)
        begin
          next_rx_st  = RX_BUSY;
          next_rx_cnt = 16'(BIT_CYC / 2);  // R08
          next_rx_bit = 4'h0;
        end
      end
      RX_BUSY:
      begin
        if (rx_cnt != 16'h0000)
          next_rx_cnt = rx_cnt - 16'h0001;
        else
        begin
          next_rx_cnt = 16'(BIT_CYC - 1);  // R08
          next_rx_bit = rx_bit + 4'h1;
          if (rx_bit == 4'h0 && rx_s2)
            next_rx_st = RX_IDLE;          // Glitch, not a start bit
          else if (rx_bit == 4'h9)
          begin
            // Stop bit low is a framing error: byte dropped
            next_rx_st    = RX_IDLE;
            next_rx_valid = rx_s2;         // R08
          end
          else if (rx_bit != 4'h0)
            next_rx_data = {rx_s2, rx_data[7:1]};
        end
      end
      default: next_rx_st = RX_IDLE;
    endcase
    // Transmitter
    if (!tx_busy)
    begin
      if (tx_start)
      begin
        next_tx_busy = 1'b1;
        next_tx_sh   = {1'b1, tx_data, 1'b0};  // R08
        next_txd     = 1'b0;
        next_tx_cnt  = 16'(BIT_CYC - 1);
        next_tx_bit  = 4'h0;
      end
    end
    else if (tx_cnt != 16'h0000)
      next_tx_cnt = tx_cnt - 16'h0001;
    else
    begin
      next_tx_cnt = 16'(BIT_CYC - 1);
      if (tx_bit == 4'h9)
      begin
        next_tx_busy = 1'b0;
        next_txd     = 1'b1;
      end
      else
      begin
        next_tx_bit = tx_bit + 4'h1;
        next_tx_sh  = {1'b1, tx_sh[9:1]};
        next_txd    = tx_sh[1];
      end
    end
  end

  // Registers; line idles high
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_s1    <= 1'b1;
      rx_s2    <= 1'b1;
      rx_st    <= RX_IDLE;
      rx_cnt   <= 16'h0000;
      rx_bit   <= 4'h0;
      rx_data  <= 8'h00;
      rx_valid <= 1'b0;
      tx_cnt   <= 16'h0000;
      tx_bit   <= 4'h0;
      tx_sh    <= 10'h3FF;
      txd      <= 1'b1;
      tx_busy  <= 1'b0;
    end
    else
    begin
      rx_s1    <= rxd;
      rx_s2    <= rx_s1;
      rx_st    <= next_rx_st;
      rx_cnt   <= next_rx_cnt;
      rx_bit   <= next_rx_bit;
      rx_data  <= next_rx_data;
      rx_valid <= next_rx_valid;
      tx_cnt   <= next_tx_cnt;
      tx_bit   <= next_tx_bit;
      tx_sh    <= next_tx_sh;
      txd      <= next_txd;
      tx_busy  <= next_tx_busy;
    end
  end

endmodule : umscp_uart
`default_nettype wire

// *** sim/umscp_cmd_parser_properties.sv ***
// Port assertions for the mode switch and command front end
`timescale 1ns/1ps
`default_nettype none
module umscp_cmd_parser_properties
  import umscp_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       uart_txd,
  input wire logic       net_rx_valid,
  input wire logic       net_rx_ready,
  input wire logic       net_tx_valid,
  input wire logic       cmd_mode,
  input wire logic       cmd_valid,
  input wire logic       cmd_is_set,
  input wire logic [3:0] cmd_grp,
  input wire logic [7:0] param_data,
  input wire logic       param_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Ready falls, then the start bit one edge later
  sequence s_frame_go;
    !net_rx_ready ##1 !uart_txd;
  endsequence
  property p_take;
    net_rx_valid && net_rx_ready |=> s_frame_go;
  endproperty
  a_take: assert property (p_take) else $error("no frame after payload take");
  // One cycle of slack while the ready flop catches up
  property p_no_take;
    cmd_mode && $past(cmd_mode) |-> !net_rx_ready;
  endproperty
  a_no_take: assert property (p_no_take) else $error("payload offered in command mode");
  property p_start;
    $fell(uart_txd) |-> !uart_txd [*8];
  endproperty
  a_start: assert property (p_start) else $error("short low bit on line");
  property p_net_pulse;
    net_tx_valid |-> !cmd_mode ##1 !net_tx_valid;
  endproperty
  a_net_pulse: assert property (p_net_pulse) else $error("bad payload pulse");
  property p_cmd_pulse;
    cmd_valid |-> cmd_mode ##1 !cmd_valid;
  endproperty
  a_cmd_pulse: assert property (p_cmd_pulse) else $error("bad command pulse");
  property p_grp;
    cmd_valid |-> cmd_grp <= GRP_ALL && !(cmd_is_set && cmd_grp == GRP_ALL);
  endproperty
  a_grp: assert property (p_grp) else $error("illegal group accepted");
  property p_param;
    param_valid |-> cmd_mode && !cmd_valid && param_data != CH_DOLLAR;
  endproperty
  a_param: assert property (p_param) else $error("bad parameter byte");
  property p_reset;
    $rose(rst_n) |-> !cmd_mode && uart_txd;
  endproperty
  a_reset: assert property (p_reset) else $error("not in data mode after reset");
endmodule : umscp_cmd_parser_properties

bind umscp_cmd_parser umscp_cmd_parser_properties u_props (.*);
`default_nettype wire

// *** sim/umscp_cmd_parser_tb_top.sv ***
// Self-checking bench for the mode switch and command front end
`timescale 1ns/1ps
`default_nettype none
module umscp_cmd_parser_tb_top;
  import umscp_pkg::*;
  localparam int BC = 16;   // Short bit time
  localparam int GC = 400;  // Short guard time
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic uart_rxd, uart_txd, net_rx_valid, net_rx_ready, net_tx_valid;
  logic cmd_mode, cmd_valid, cmd_is_set, param_valid, h_valid;
  logic [7:0] net_rx_data, net_tx_data, param_data, h_byte, rb;
  logic [3:0] cmd_grp;
  logic [7:0] q_uart[$], q_net[$], q_cmd[$], q_par[$];  // Expected results
  int fail_count = 0;
  int compares = 0;
  string prm, kw, nm, grp[12];

  always #12.5 clk = ~clk;

  umscp_cmd_parser #(.BIT_CYC(BC), .GUARD_CYC(GC)) u_dut (.*);
  umscp_host_model #(.BIT_CYC(BC)) u_host (.clk(clk), .line_in(uart_txd),
    .line_out(uart_rxd), .rx_byte(h_byte), .rx_valid(h_valid));

  task cmp(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  task automatic take(ref logic [7:0] q[$], input string n, input logic [7:0] g);
    cmp(n, q.size() > 0 ? q.pop_front() : 8'hxx, g);
  endtask : take
  task end_of_test;
    if (fail_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  // Bounded wait for expected UART and network bytes
  task drain;
    int n;
    for (n = 0; q_uart.size() + q_net.size() > 0 && n < 20000; n++)
      @(posedge clk);
    if (n >= 20000) fail_count++;
    repeat (2 * BC) @(posedge clk);
    #2;
  endtask : drain
  task host_str(input string s, input bit fwd);
    for (int i = 0; i < s.len(); i++)
    begin
      if (fwd) q_net.push_back(s[i]);
      u_host.send(s[i], 0);
    end
  endtask : host_str
  task exp_str(input string s);
    for (int i = 0; i < s.len(); i++) q_uart.push_back(s[i]);
  endtask : exp_str
  // Dollar arrives as space, space as token end
  task exp_par(input string s);
    for (int i = 0; i < s.len(); i++)
      q_par.push_back(s[i] == "$" ? CH_SPACE : s[i] == " " ? CH_NUL : s[i]);
  endtask : exp_par
  // Payload is held until taken, then expected on the line
  task net_send(input logic [7:0] b, input int lim);
    int n;
    net_rx_data = b;
    net_rx_valid = 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (net_rx_ready !== 1'b1 && n < lim);
    if (n >= lim) fail_count++;
    q_uart.push_back(b);
    #2 net_rx_valid = 1'b0;
    net_rx_data = ~b;
    @(posedge clk);
    #2;
  endtask : net_send
  // Negative code means an error reply
  task do_cmd(input string ln, input int code, input string par);
    exp_par(par);
    if (code < 0) exp_str("ERR\r\n");
    else q_cmd.push_back(8'(code));
    exp_str(prm);
    host_str({ln, "\r"}, 1'b0);
    drain;
  endtask : do_cmd

  // Result watcher
  always @(posedge clk)
  begin
    if (net_tx_valid === 1'b1) take(q_net, "net_tx_data", net_tx_data);
    if (param_valid === 1'b1) take(q_par, "param_data", param_data);
    if (cmd_valid === 1'b1) take(q_cmd, "cmd", {3'h0, cmd_is_set, cmd_grp});
    if (h_valid === 1'b1) take(q_uart, "uart_txd", h_byte);
  end

  initial
  begin
    repeat (80000) @(posedge clk);
    fail_count++;
    end_of_test;
  end

  initial
  begin
    void'($urandom(32'hbf58));
    net_rx_valid = 1'b0;
    net_rx_data = 8'h00;
    grp = '{"adhoc", "broadcast", "comm", "dns", "ftp", "ip", "option", "sys", "time",
            "uart", "wlan", "everything"};
    prm = string'({CH_LT, VER_MAJ, CH_DOT, VER_MI1, VER_MI2, CH_GT, CH_SPACE});
    repeat (6) @(posedge clk);
    #2 rst_n = 1'b1;
    cmp("cmd_mode", 8'h00, 8'(cmd_mode));
    repeat (2) net_send(8'($urandom), 5000);
    repeat (2)
    begin
      rb = 8'($urandom);
      q_net.push_back(rb);
      u_host.send(rb, 3);
    end
    host_str("a$$$", 1'b1);
    repeat (GC) @(posedge clk);
    #2 host_str("$$$$", 1'b1);
    drain;
    repeat (GC) @(posedge clk);
    #2 cmp("cmd_mode", 8'h00, 8'(cmd_mode));
    exp_str("CMD\r\n");
    host_str("$$$", 1'b1);
    drain;
    cmp("cmd_mode", 8'h01, 8'(cmd_mode));
    fork
      net_send(8'($urandom), 90000);
    join_none
    do_cmd("get  w\n", 32'h0A, "");
    do_cmd("set u b", 32'h19, "b");
    do_cmd("set wlan ssid MY$NET", 32'h1A, "ssid MY$NET");
    do_cmd("s uart", -1, "");
    do_cmd("GET wlan", -1, "");
    do_cmd("set e", -1, "");
    do_cmd("get", -1, "");
    for (int i = 0; i < 12; i++)
    begin
      kw = i < 6 ? "set " : "get ";
      nm = i % 2 ? grp[i].substr(0, 0) : grp[i];
      do_cmd({kw, nm}, (i < 6) * 16 + i, "");
    end
    exp_str("EXIT\r\n");
    host_str("exit\r", 1'b0);
    drain;
    cmp("cmd_mode", 8'h00, 8'(cmd_mode));
    drain;
    cmp("left", 8'h00, 8'(q_uart.size() + q_net.size() + q_cmd.size() + q_par.size()));
    end_of_test;
  end
endmodule : umscp_cmd_parser_tb_top
`default_nettype wire

// *** sim/umscp_host_model.sv ***
// Host terminal model: 8N1 sender and receiver on the serial line
`timescale 1ns/1ps
`default_nettype none
module umscp_host_model #(
  parameter int BIT_CYC = 16
) (
  input  wire logic clk,
  input  wire logic line_in,
  output logic      line_out,
  output logic [7:0] rx_byte,
  output logic      rx_valid
);
  initial
  begin
    line_out = 1'b1;
    rx_valid = 1'b0;
    rx_byte = 8'h00;
  end
  // LSB first frame; a long stop bit makes a slow host
  task automatic send(input logic [7:0] b, input int gap);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      line_out = f[i];
      repeat (i == 9 ? BIT_CYC * (gap + 1) : BIT_CYC) @(posedge clk);
      #2;
    end
  endtask : send
  // Mid-bit sampling; a bad stop bit drops the byte
  always
  begin
    @(negedge line_in);
    repeat (BIT_CYC / 2) @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT_CYC) @(posedge clk);
      rx_byte[i] <= line_in;
    end
    repeat (BIT_CYC) @(posedge clk);
    rx_valid <= line_in;
    @(posedge clk);
    rx_valid <= 1'b0;
  end
endmodule : umscp_host_model
`default_nettype wire
